// ===== rtl/fss_pkg.sv
// fss_pkg: constants and types for the frame security sequencer
// assumes a 32-bit apb slave with word-aligned registers
`default_nettype none
package fss_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] FLAG_OFS   = 8'h04;
  localparam logic [7:0] INDEX_OFS  = 8'h08;
  localparam logic [7:0] AUX_OFS    = 8'h0c;
  localparam logic [7:0] LEN_OFS    = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  // control fields
  localparam int CTRL_TX_ENC  = 0;
  localparam int CTRL_TX_ST   = 1;
  localparam int CTRL_RX_DEC  = 2;
  localparam int CTRL_MANUAL  = 3;
  localparam int CTRL_CRC     = 4;
  localparam int CTRL_DBG1    = 5;
  localparam int CTRL_DBG2    = 6;
  localparam int CTRL_RXFULL  = 7;
  localparam int CTRL_SECURITY_ENABLED_BIT   = 8;
  // flag fields, write one to clear
  localparam int FLG_RX_DONE  = 0;
  localparam int FLG_RX_AUTH  = 1;
  localparam int FLG_TX_ENC   = 2;
  localparam int FLG_TX_DONE  = 3;
  localparam int FLG_TX_SIZE  = 4;
  localparam int FLG_FRM_ERR  = 5;
  localparam int FLG_RX_FRM   = 6;
  localparam int FLG_RX_DELIM = 7;
  localparam int FLAG_W       = 8;
  // frame limits and layer codes
  localparam logic [7:0] MAX_FRAME_LEN = 8'd127;
  localparam logic [7:0] CRC_LEN       = 8'd2;
  localparam logic [1:0] LAYER_LINK    = 2'b00;
  localparam logic [1:0] LAYER_NET     = 2'b01;
  localparam logic [1:0] LAYER_BOTH    = 2'b10;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  // buffer selects
  typedef enum logic [1:0] {BUF_MAIN, BUF_DBG1, BUF_DBG2} fss_buf_type;
endpackage : fss_pkg
`default_nettype wire

// ===== rtl/fss_index_calc.sv
// fss_index_calc: forms secured-region indices from pointers and length
// assumes pointers and length are stable while the result is sampled
`default_nettype none
module fss_index_calc (
  // pointer sources
  input  wire logic [6:0] hdrPtr,
  input  wire logic [6:0] payPtr,
  input  wire logic [7:0] frameLen,
  // results
  output logic      [6:0] hdrIdx,
  output logic      [6:0] payIdx,
  output logic      [6:0] endIdx
);
  import fss_pkg::*;
  logic [7:0] lastByte;
  // end index points at last payload byte ahead of the crc
  always_comb begin
    lastByte = (frameLen > CRC_LEN) ? frameLen - CRC_LEN : 8'h00;
    hdrIdx   = hdrPtr;
    payIdx   = payPtr;
    endIdx   = lastByte[6:0];
  end
endmodule : fss_index_calc
`default_nettype wire

// ===== rtl/fss_mic_check.sv
// fss_mic_check: compares computed and received mic tags
// assumes the cipher core presents both tags when it reports done
`default_nettype none
module fss_mic_check #(
  parameter int TAG_W = 128
) (
  // tags
  input  wire logic [TAG_W-1:0] calcTag,
  input  wire logic [TAG_W-1:0] rxTag,
  input  wire logic [4:0]       tagLen,
  // result
  output logic                  tagMatch
);
  import fss_pkg::*;
  logic [TAG_W-1:0] mask;
  // only the first tagLen bytes take part
  always_comb begin
    mask = '0;
    for (int i = 0; i < TAG_W / 8; i++) begin
      if (i < int'(tagLen)) begin
        mask[i*8 +: 8] = 8'hff;
      end
    end
    tagMatch = ((calcTag ^ rxTag) & mask) == '0;
  end
endmodule : fss_mic_check
`default_nettype wire

// ===== rtl/fss_sequencer.sv
// fss_sequencer: control sequencer for layered frame security
// assumes an external cipher core, radio and acceptance filter on plain ports
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`default_nettype none
module fss_sequencer #(
  parameter int TAG_W = 128
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // frame parser and filter
  input  wire logic             rxAccept,
  input  wire logic             rxFrameError,
  input  wire logic [7:0]       rxFrameLen,
  input  wire logic             rxSecurityEnabled,
  input  wire logic [23:0]      rxAuxHeader,
  // cipher core
  output logic                  cipherStart,
  output logic                  cipherDecrypt,
  output fss_pkg::fss_buf_type  cipherBuf,
  input  wire logic             cipherDone,
  input  wire logic [4:0]       cipherTagLen,
  input  wire logic [TAG_W-1:0] calcTag,
  input  wire logic [TAG_W-1:0] rxTag,
  // radio
  output logic                  radioSend,
  input  wire logic             radioDone,
  // secured indices
  output logic      [6:0]       secHdrIdx,
  output logic      [6:0]       secPayIdx,
  output logic      [6:0]       secEndIdx
);
  import fss_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_RX_RUN, ST_ENC_RUN, ST_TX_SEC, ST_TX_CRC, ST_TX_SEND
  } fss_state_type;

  typedef struct packed {
    fss_state_type      st;
    logic [31:0]        ctrl;
    logic [FLAG_W-1:0]  flags;
    logic [6:0]         hdr;
    logic [6:0]         pay;
    logic [6:0]         endi;
    logic [23:0]        aux;
    logic [7:0]         len;
    logic               linkPassDone;
    logic               start;
    logic               send;
    logic [31:0]        rdata;
  } fss_regs_type;

  fss_regs_type s_r;
  fss_regs_type s_nxt;

  logic [6:0] linkHdr;
  logic [6:0] linkPay;
  logic [6:0] netHdr;
  logic [6:0] netPay;
  logic [6:0] calcHdr;
  logic [6:0] calcPay;
  logic [6:0] calcEnd;
  logic [6:0] txHdr;
  logic [6:0] txPay;
  logic       tagMatch;
  logic       apbWr;
  logic       apbRd;
  logic [1:0] layer;
  logic [8:0] grownLen;

  // ----------------------------------------------------------------
  // aux header fields
  // ----------------------------------------------------------------
  // layer select decode
  always_comb begin
    layer   = s_r.aux[1:0];
    linkHdr = 7'h01;
    linkPay = {1'b0, s_r.aux[7:2]};
    netHdr  = s_r.aux[8:2];
    netPay  = s_r.aux[15:9];
    if (layer == LAYER_BOTH) begin
      netHdr  = s_r.aux[15:9];
      netPay  = s_r.aux[22:16];
      linkPay = {1'b0, s_r.aux[7:2]};
    end
  end

  fss_index_calc u_rx_idx (
    .hdrPtr   ((layer == LAYER_NET) ? netHdr : linkHdr),
    .payPtr   ((layer == LAYER_NET) ? netPay : linkPay),
    .frameLen (s_r.len),
    .hdrIdx   (calcHdr),
    .payIdx   (calcPay),
    .endIdx   (calcEnd)
  );

  fss_index_calc u_tx_idx (
    .hdrPtr   (linkHdr),
    .payPtr   (linkPay),
    .frameLen (s_r.len),
    .hdrIdx   (txHdr),
    .payIdx   (txPay),
    .endIdx   ()
  );

  fss_mic_check #(
    .TAG_W (TAG_W)
  ) u_mic (
    .calcTag  (calcTag),
    .rxTag    (rxTag),
    .tagLen   (cipherTagLen),
    .tagMatch (tagMatch)
  );

  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && !penable && !pwrite;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt       = s_r;
    s_nxt.start = 1'b0;
    s_nxt.send  = 1'b0;
    grownLen    = {1'b0, s_r.len} + {4'h0, cipherTagLen};

    // register writes; flags are write one to clear
    if (apbWr) begin
      unique case (paddr)
        CTRL_OFS: begin
          if (s_r.st == ST_IDLE) begin
            s_nxt.ctrl = pwdata;
          end else begin
            s_nxt.ctrl = {pwdata[31:3], s_r.ctrl[2:0]};
          end
        end
        FLAG_OFS: s_nxt.flags = s_r.flags & ~pwdata[FLAG_W-1:0];
        INDEX_OFS: begin
          s_nxt.hdr  = pwdata[6:0];
          s_nxt.pay  = pwdata[14:8];
          s_nxt.endi = pwdata[22:16];
        end
        AUX_OFS: s_nxt.aux = pwdata[23:0];
        LEN_OFS: s_nxt.len = pwdata[7:0];
        default: ;
      endcase
    end

    if (rxAccept) begin
      s_nxt.flags[FLG_RX_FRM]   = 1'b1;
      s_nxt.flags[FLG_RX_DELIM] = 1'b1;
      s_nxt.ctrl[CTRL_RXFULL]   = 1'b1;
      s_nxt.ctrl[CTRL_SECURITY_ENABLED_BIT]    = rxSecurityEnabled;
      s_nxt.aux                 = rxAuxHeader;
      s_nxt.len                 = rxFrameLen;
      s_nxt.linkPassDone        = 1'b0;
    end
    if (rxFrameError) begin
      s_nxt.flags[FLG_FRM_ERR] = 1'b1;
    end
    if (s_r.flags[FLG_RX_FRM] && s_r.st == ST_IDLE && !s_r.ctrl[CTRL_MANUAL]
        && s_r.ctrl[CTRL_SECURITY_ENABLED_BIT] && !s_r.linkPassDone && !s_r.ctrl[CTRL_RX_DEC]) begin
      s_nxt.hdr  = calcHdr;
      s_nxt.pay  = calcPay;
      s_nxt.endi = calcEnd;
    end

    unique case (s_r.st)
      ST_IDLE: begin
        if (s_r.ctrl[CTRL_RX_DEC]) begin
          s_nxt.st    = ST_RX_RUN;
          s_nxt.start = 1'b1;
        end else if (s_r.ctrl[CTRL_TX_ENC]) begin
          s_nxt.st    = ST_ENC_RUN;
          s_nxt.start = 1'b1;
          s_nxt.hdr   = netHdr;
          s_nxt.pay   = netPay;
          s_nxt.endi  = s_r.len[6:0];
        end else if (s_r.ctrl[CTRL_TX_ST]) begin
          s_nxt.st    = ST_TX_SEC;
          s_nxt.start = s_r.ctrl[CTRL_SECURITY_ENABLED_BIT];
          if (s_r.ctrl[CTRL_SECURITY_ENABLED_BIT] && !s_r.ctrl[CTRL_MANUAL]) begin
            s_nxt.hdr  = txHdr;
            s_nxt.pay  = txPay;
            s_nxt.endi = s_r.len[6:0];
          end
          if (!s_r.ctrl[CTRL_SECURITY_ENABLED_BIT]) begin
            s_nxt.st = ST_TX_CRC;
          end
        end
      end
      ST_RX_RUN: begin
        if (cipherDone) begin
          s_nxt.st                = ST_IDLE;
          s_nxt.ctrl[CTRL_RX_DEC] = 1'b0;
          if (!tagMatch) begin
            s_nxt.flags[FLG_RX_AUTH] = 1'b1;
          end else begin
            s_nxt.flags[FLG_RX_DONE] = 1'b1;
            if (layer == LAYER_BOTH && !s_r.linkPassDone) begin
              s_nxt.linkPassDone = 1'b1;
              s_nxt.hdr  = netHdr;
              s_nxt.pay  = netPay;
              s_nxt.endi = {2'b00, cipherTagLen};
            end
          end
        end
      end
      ST_ENC_RUN, ST_TX_SEC: begin
        if (cipherDone) begin
          // mic grows length and end index unless the length would exceed MAX_FRAME_LEN
          if (grownLen > {1'b0, MAX_FRAME_LEN}) begin
            s_nxt.flags[FLG_TX_SIZE] = 1'b1;
          end else begin
            s_nxt.len  = grownLen[7:0];
            s_nxt.endi = s_r.endi + 7'(cipherTagLen);
          end
          if (s_r.st == ST_ENC_RUN) begin
            s_nxt.st                 = ST_IDLE;
            s_nxt.ctrl[CTRL_TX_ENC]  = 1'b0;
            s_nxt.flags[FLG_TX_ENC]  = 1'b1;
          end else begin
            s_nxt.st = ST_TX_CRC;
          end
        end
      end
      ST_TX_CRC: begin
        if (s_r.ctrl[CTRL_CRC]) begin
          if ({1'b0, s_r.len} + {1'b0, CRC_LEN} > {1'b0, MAX_FRAME_LEN}) begin
            s_nxt.flags[FLG_TX_SIZE] = 1'b1;
          end else begin
            s_nxt.len = s_r.len + CRC_LEN;
          end
        end
        s_nxt.st   = ST_TX_SEND;
        s_nxt.send = 1'b1;
      end
      ST_TX_SEND: begin
        if (radioDone) begin
          s_nxt.st               = ST_IDLE;
          s_nxt.ctrl[CTRL_TX_ST] = 1'b0;
          if (!s_nxt.flags[FLG_TX_SIZE] && !s_nxt.flags[FLG_FRM_ERR]) begin
            s_nxt.flags[FLG_TX_DONE] = 1'b1;
          end
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase

    // read data captured in setup phase
    if (apbRd) begin
      unique case (paddr)
        CTRL_OFS:   s_nxt.rdata = s_r.ctrl;
        FLAG_OFS:   s_nxt.rdata = {24'h0, s_r.flags};
        INDEX_OFS:  s_nxt.rdata = {9'h0, s_r.endi, 1'b0, s_r.pay, 1'b0, s_r.hdr};
        AUX_OFS:    s_nxt.rdata = {8'h0, s_r.aux};
        LEN_OFS:    s_nxt.rdata = {24'h0, s_r.len};
        STATUS_OFS: s_nxt.rdata = {28'h0, s_r.linkPassDone, s_r.st};
        default:    s_nxt.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '{st: ST_IDLE, ctrl: CTRL_RESET, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata        = s_r.rdata;
  assign pready        = 1'b1;
  assign pslverr       = psel && penable && (paddr > STATUS_OFS || paddr[1:0] != 2'b00);
  assign cipherStart   = s_r.start;
  assign cipherDecrypt = (s_r.st == ST_RX_RUN);
  assign cipherBuf     = s_r.ctrl[CTRL_DBG1] ? BUF_DBG1 :
                         s_r.ctrl[CTRL_DBG2] ? BUF_DBG2 : BUF_MAIN;
  assign radioSend     = s_r.send;
  assign secHdrIdx     = s_r.hdr;
  assign secPayIdx     = s_r.pay;
  assign secEndIdx     = s_r.endi;
endmodule : fss_sequencer
`default_nettype wire

// ===== sim/fss_sequencer_checker.sv
// fss_sequencer_checker: port assertions for the sequencer
// assumes one clock domain; bound to every sequencer instance
`default_nettype none
module fss_sequencer_checker
  import fss_pkg::*;
(
  // watched ports
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic        rxAccept,
  input wire logic        rxSecurityEnabled,
  input wire logic [7:0]  rxFrameLen,
  input wire logic [23:0] rxAuxHeader,
  input wire logic        cipherStart,
  input wire logic        cipherDecrypt,
  input wire logic        cipherDone,
  input wire logic        radioSend,
  input wire logic [6:0]  secHdrIdx,
  input wire logic [6:0]  secPayIdx,
  input wire logic [6:0]  secEndIdx
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic [3:0] rxAge;
  logic       busy;
  // cycles since the host last wrote the decrypt trigger, and cipher busy
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rxAge <= 4'hf;
      busy  <= 1'b0;
    end else begin
      if (psel && penable && pwrite && paddr == CTRL_OFS && pwdata[CTRL_RX_DEC]) rxAge <= 4'h0;
      else if (rxAge != 4'hf) rxAge <= rxAge + 4'h1;
      if (cipherStart) busy <= 1'b1;
      else if (cipherDone) busy <= 1'b0;
    end
  end
  sequence acc_s(logic [1:0] lay);
    rxAccept && rxSecurityEnabled && rxAuxHeader[1:0] == lay;
  endsequence
  err_unmapped_a: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
    else $error("unmapped access without error");
  cstart_pulse_a: assert property (cipherStart |=> !cipherStart)
    else $error("cipher start longer than one cycle");
  rsend_pulse_a: assert property (radioSend |=> !radioSend)
    else $error("radio send longer than one cycle");
  rx_host_start_a: assert property ($rose(cipherDecrypt) |-> rxAge <= 4'h3)
    else $error("receive run without host trigger");
  no_overlap_a: assert property (cipherStart |-> !busy)
    else $error("cipher restarted while busy");
  link_index_a: assert property (acc_s(LAYER_LINK) |-> ##[1:2]
    (secHdrIdx == 7'h01 && secPayIdx == {1'b0, rxAuxHeader[7:2]}))
    else $error("link indices not loaded");
  net_index_a: assert property (acc_s(LAYER_NET) |-> ##[1:2]
    (secHdrIdx == rxAuxHeader[8:2] && secPayIdx == rxAuxHeader[15:9]))
    else $error("net indices not loaded");
  end_index_a: assert property (acc_s(LAYER_BOTH) |-> ##[1:2]
    (secPayIdx == {1'b0, rxAuxHeader[7:2]} && secEndIdx == rxFrameLen[6:0] - 7'd2))
    else $error("two-layer indices not loaded");
endmodule : fss_sequencer_checker
bind fss_sequencer fss_sequencer_checker chk (.*);
`default_nettype wire

// ===== sim/fss_core_model.sv
// fss_core_model: cipher core and radio answering the sequencer
// assumes single-cycle start and send pulses; slow selects long latency
`default_nettype none
module fss_core_model #(
  parameter int TAG_W = 16
) (
  // control
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        cipherStart,
  input wire logic        radioSend,
  input wire logic        badTag,
  input wire logic        slow,
  input wire logic [4:0]  tagLen,
  // answers
  output logic             cipherDone,
  output logic             radioDone,
  output logic [4:0]       cipherTagLen,
  output logic [TAG_W-1:0] calcTag,
  output logic [TAG_W-1:0] rxTag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]       cCnt;
  logic [3:0]       rCnt;
  logic [TAG_W-1:0] pat;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cCnt       <= 4'h0;
      rCnt       <= 4'h0;
      cipherDone <= 1'b0;
      radioDone  <= 1'b0;
    end else begin
      cipherDone <= cCnt == 4'h1;
      radioDone  <= rCnt == 4'h1;
      if (cipherStart) cCnt <= slow ? 4'hc : 4'h2;
      else if (cCnt != 4'h0) cCnt <= cCnt - 4'h1;
      if (radioSend) rCnt <= slow ? 4'hc : 4'h2;
      else if (rCnt != 4'h0) rCnt <= rCnt - 4'h1;
    end
  end
  // tags only meaningful alongside done; otherwise inverted pattern
  assign pat          = TAG_W'(32'h5aa5c33c);
  assign cipherTagLen = tagLen;
  assign calcTag      = cipherDone ? pat : ~pat;
  assign rxTag        = (cipherDone && !badTag) ? pat : ~pat;
endmodule : fss_core_model
`default_nettype wire

// ===== sim/fss_sequencer_tb_top.sv
// fss_sequencer_tb_top: self-checking bench for the sequencer
// assumes the core model on the far side and an apb master here
`default_nettype none
module fss_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fss_pkg::*;
  logic        clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, lastErr;
  logic        rxAccept, rxFrameError, rxSecurityEnabled, badTag, slow;
  logic        cipherStart, cipherDecrypt, cipherDone, radioSend, radioDone;
  logic [7:0]  paddr, rxFrameLen;
  logic [31:0] pwdata, prdata, q;
  logic [23:0] rxAuxHeader;
  logic [4:0]  cipherTagLen, tagLen;
  logic [15:0] calcTag, rxTag;
  logic [6:0]  secHdrIdx, secPayIdx, secEndIdx;
  fss_buf_type cipherBuf;
  int          n_mismatch, tests_run, nStart, nSend, cyc, s, n;
  fss_sequencer #(.TAG_W(16)) DUT (.*);
  fss_core_model #(.TAG_W(16)) partner (.*);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (cipherStart === 1'b1) nStart++;
    if (radioSend === 1'b1) nSend++;
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    q       = prdata;
    lastErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task waitbit(input logic [7:0] a, input int b, input logic v);
    apb(1'b0, a, 32'h0);
    repeat (60) if (q[b] !== v) apb(1'b0, a, 32'h0);
    chk(32'(q[b]), 32'(v));
  endtask : waitbit
  task accept(input logic [7:0] len, input logic [23:0] aux);
    @(posedge clk_sys);
    rxAccept          <= 1'b1;
    rxFrameLen        <= len;
    rxAuxHeader       <= aux;
    rxSecurityEnabled <= 1'b1;
    @(posedge clk_sys);
    rxAccept <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : accept
  function automatic logic [31:0] idx(input logic [6:0] h, input logic [6:0] p);
    return 32'({h, p});
  endfunction : idx
  task t_regs;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(q, CTRL_RESET);
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(lastErr), 32'h1);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(32'(lastErr), 32'h0);
    $display("test regs done");
  endtask : t_regs
  task t_rx_link;
    s = nStart;
    tagLen <= 5'd8;
    accept(8'd20, 24'h000028);
    apb(1'b0, FLAG_OFS, 32'h0);
    chk(32'(q[7:6]), 32'h3);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(32'(q[CTRL_RXFULL]), 32'h1);
    chk(32'(secEndIdx), 32'd18);
    chk(32'(nStart), 32'(s));
    apb(1'b1, CTRL_OFS, 32'ha4);
    @(negedge clk_sys);
    chk(32'(cipherBuf), 32'(BUF_DBG1));
    waitbit(FLAG_OFS, FLG_RX_DONE, 1'b1);
    chk(32'(q[FLG_RX_AUTH]), 32'h0);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(32'(q[CTRL_RX_DEC]), 32'h0);
    apb(1'b1, FLAG_OFS, 32'hff);
    $display("test rx link done");
  endtask : t_rx_link
  task t_rx_fail;
    badTag <= 1'b1;
    apb(1'b1, CTRL_OFS, 32'h84);
    @(negedge clk_sys);
    chk(32'(cipherBuf), 32'(BUF_MAIN));
    waitbit(FLAG_OFS, FLG_RX_AUTH, 1'b1);
    chk(32'(q[FLG_RX_DONE]), 32'h0);
    apb(1'b1, CTRL_OFS, 32'h0);
    apb(1'b1, FLAG_OFS, 32'hff);
    badTag <= 1'b0;
    $display("test rx fail done");
  endtask : t_rx_fail
  task t_rx_both;
    s = nStart;
    tagLen <= 5'd8;
    accept(8'd40, {1'b0, 7'h30, 7'h20, 1'b0, 6'h05, 2'b10});
    chk(idx(secHdrIdx, secPayIdx), idx(7'h01, 7'h05));
    apb(1'b1, CTRL_OFS, 32'h84);
    waitbit(FLAG_OFS, FLG_RX_DONE, 1'b1);
    chk(idx(secHdrIdx, secPayIdx), idx(7'h20, 7'h30));
    chk(32'(secEndIdx), 32'd8);
    apb(1'b1, FLAG_OFS, 32'hff);
    apb(1'b1, CTRL_OFS, 32'hc4);
    @(negedge clk_sys);
    chk(32'(cipherBuf), 32'(BUF_DBG2));
    waitbit(FLAG_OFS, FLG_RX_DONE, 1'b1);
    chk(32'(nStart), 32'(s + 2));
    accept(8'd30, {8'h00, 7'h0c, 7'h0b, 2'b01});
    chk(idx(secHdrIdx, secPayIdx), idx(7'h0b, 7'h0c));
    apb(1'b1, CTRL_OFS, 32'h0);
    apb(1'b1, FLAG_OFS, 32'hff);
    rxSecurityEnabled <= 1'b0;
    $display("test rx both done");
  endtask : t_rx_both
  task t_tx_enc;
    slow   <= 1'b1;
    tagLen <= 5'd4;
    apb(1'b1, AUX_OFS, {8'h00, 1'b0, 7'h30, 7'h20, 1'b0, 6'h05, 2'b10});
    apb(1'b1, LEN_OFS, 32'd40);
    s = nStart;
    n = nSend;
    apb(1'b1, CTRL_OFS, 32'h1);
    apb(1'b1, CTRL_OFS, 32'h5);
    waitbit(FLAG_OFS, FLG_TX_ENC, 1'b1);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(32'(q[2:0]), 32'h0);
    chk(32'(nStart), 32'(s + 1));
    chk(32'(nSend), 32'(n));
    chk(idx(secHdrIdx, secPayIdx), idx(7'h20, 7'h30));
    chk(32'(secEndIdx), 32'd44);
    apb(1'b0, LEN_OFS, 32'h0);
    chk(q & 32'hff, 32'd44);
    apb(1'b1, FLAG_OFS, 32'hff);
    slow <= 1'b0;
    $display("test tx encrypt done");
  endtask : t_tx_enc
  task t_tx_send;
    apb(1'b1, AUX_OFS, 32'h28);
    apb(1'b1, LEN_OFS, 32'd30);
    n = nSend;
    apb(1'b1, CTRL_OFS, 32'h112);
    waitbit(FLAG_OFS, FLG_TX_DONE, 1'b1);
    chk(32'(nSend), 32'(n + 1));
    chk(idx(secHdrIdx, secPayIdx), idx(7'h01, 7'h0a));
    chk(32'(secEndIdx), 32'd34);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(32'(q[CTRL_TX_ST]), 32'h0);
    apb(1'b0, LEN_OFS, 32'h0);
    chk(q & 32'hff, 32'd36);
    apb(1'b1, FLAG_OFS, 32'hff);
    apb(1'b1, LEN_OFS, 32'd126);
    apb(1'b1, CTRL_OFS, 32'h12);
    waitbit(CTRL_OFS, CTRL_TX_ST, 1'b0);
    apb(1'b0, FLAG_OFS, 32'h0);
    chk(32'(q[4:3]), 32'h2);
    $display("test tx send done");
  endtask : t_tx_send
  task t_tx_manual;
    apb(1'b1, FLAG_OFS, 32'hff);
    apb(1'b1, LEN_OFS, 32'd30);
    apb(1'b1, CTRL_OFS, 32'h108);
    apb(1'b1, INDEX_OFS, 32'h0014_0703);
    @(posedge clk_sys);
    rxFrameError <= 1'b1;
    @(posedge clk_sys);
    rxFrameError <= 1'b0;
    apb(1'b1, CTRL_OFS, 32'h10a);
    waitbit(CTRL_OFS, CTRL_TX_ST, 1'b0);
    chk(idx(secHdrIdx, secPayIdx), idx(7'h03, 7'h07));
    chk(32'(secEndIdx), 32'h18);
    apb(1'b0, FLAG_OFS, 32'h0);
    chk(32'(q[5:3]), 32'h4);
    apb(1'b1, FLAG_OFS, 32'hff);
    apb(1'b1, CTRL_OFS, 32'h0);
    $display("test tx manual done");
  endtask : t_tx_manual
  task report_and_stop;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  initial begin
    {reset_n, psel, penable, pwrite, rxAccept, rxFrameError} = 6'h0;
    {rxSecurityEnabled, badTag, slow} = 3'h0;
    {paddr, rxFrameLen, pwdata, rxAuxHeader, tagLen} = '0;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_regs();
    t_rx_link();
    t_rx_fail();
    t_rx_both();
    t_tx_enc();
    t_tx_send();
    t_tx_manual();
    report_and_stop();
  end
endmodule : fss_sequencer_tb_top
`default_nettype wire
